// ---- verilog/qdc_top.sv ----
// qdc_top: two-wire slave, load strobe and reset control of a quad converter.
// assumes scl and sda come from an external bus master and are resolved by
// the bench from sda_oe with a pull-up; apb master on pclk.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module qdc_top
  import qdc_pkg::*;
(
  // apb clock and reset
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  // apb slave
  input  wire logic [7:0]                     paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [31:0]                    pwdata,
  output logic                                pready,
  output logic [31:0]                         prdata,
  output logic                                pslverr,
  // two-wire bus
  input  wire logic                           scl,
  input  wire logic                           sda_in,
  output logic                                sda_out,
  output logic                                sda_oe,
  // strobes and straps
  input  wire logic                           load_strobe_n,
  input  wire logic                           span_select,
  input  wire logic                           addr_strap_bit0,
  input  wire logic                           addr_strap_bit1,
  input  wire logic                           reset_level_select,
  input  wire logic                           dac_reset_n,
  // converter side
  output logic [qdc_pkg::QDC_NCH-1:0][qdc_pkg::QDC_DW-1:0] dac_code,
  output logic                                span_double,
  output logic                                ref_out_en
);
  import qdc_pkg::*;

  typedef struct packed {
    qdc_st_t       st;
    logic [3:0]    bitc;
    logic [1:0]    bidx;
    logic [7:0]    sh;
    logic [23:0]   sh24;
    logic          rw;
    logic          ackd;
    logic [7:0]    tx;
    logic          txsel;
    logic          oe;
    logic [3:0]    sel;
    logic          sclp;
    logic          sdap;
    logic          ldp;
    logic          rstp;
    logic          por;
    logic          ref_en;
    logic          swld;
    logic [31:0]   rdata;
  } qdc_top_t;

  qdc_top_t r_reg;
  qdc_top_t r_next;

  logic [QDC_NPIN-1:0]               pin;
  logic [QDC_NCH-1:0][QDC_DW-1:0]    ch_in;
  logic [QDC_NCH-1:0][QDC_DW-1:0]    ch_dac;
  logic [QDC_NCH-1:0]                ch_pend;
  logic [QDC_NCH-1:0]                ch_wr;
  logic [QDC_NCH-1:0]                ch_upd;
  logic [QDC_DW-1:0]                 wr_data;
  logic                              ch_init;
  logic [QDC_DW-1:0]                 init_val;
  logic                              scl_r;
  logic                              scl_f;
  logic                              start;
  logic                              stop;
  logic [7:0]                        rx_byte;
  logic [6:0]                        my_addr;
  logic                              exec;
  logic [3:0]                        cmd;
  logic [1:0]                        rd_idx;
  logic [QDC_DW-1:0]                 rd_word;
  logic                              ld_fall;
  logic                              ld_ok;
  logic                              hit;
  logic [31:0]                       rd_v;

  // all outside levels pass two flops first
  qdc_sync #(
    .W   (QDC_NPIN),
    .RST (QDC_PIN_RST)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({dac_reset_n, reset_level_select, addr_strap_bit1, addr_strap_bit0,
               span_select, load_strobe_n, sda_in, scl}),
    .q       (pin)
  );

  for (genvar g = 0; g < QDC_NCH; g++) begin : g_ch
    qdc_chan u_chan (
      .pclk     (pclk),
      .presetn  (presetn),
      .init     (ch_init),
      .init_val (init_val),
      .wr       (ch_wr[g]),
      .wdata    (wr_data),
      .upd      (ch_upd[g]),
      .in_code  (ch_in[g]),
      .dac_code (ch_dac[g]),
      .pending  (ch_pend[g])
    );
  end

  // link edges and bus conditions, from the second flop only
  always_comb begin
    scl_r   = pin[QDC_P_SCL] & ~r_reg.sclp;
    scl_f   = ~pin[QDC_P_SCL] & r_reg.sclp;
    start   = r_reg.sclp & pin[QDC_P_SCL] & r_reg.sdap & ~pin[QDC_P_SDA];
    stop    = r_reg.sclp & pin[QDC_P_SCL] & ~r_reg.sdap & pin[QDC_P_SDA];
    rx_byte = {r_reg.sh[6:0], pin[QDC_P_SDA]};
    my_addr = {QDC_ADDR_HI, pin[QDC_P_A1], pin[QDC_P_A0]};
  end

  // reset handling and the common load decision
  always_comb begin
    // por waits for the reset pin to be high
    ch_init  = (r_reg.rstp & ~pin[QDC_P_RST])
             | (~r_reg.por & pin[QDC_P_RST]);
    init_val = pin[QDC_P_RSEL] ? QDC_MID : QDC_ZERO;
    ld_ok    = pin[QDC_P_RST] & r_reg.por;
    ld_fall  = r_reg.ldp & ~pin[QDC_P_LD];
  end

  // read source for the two-wire read: lowest selected channel
  always_comb begin
    rd_idx = 2'd0;
    for (int i = QDC_NCH - 1; i >= 0; i--) begin
      if (r_reg.sel[i]) begin
        rd_idx = 2'(i);
      end
    end
    rd_word = ch_in[rd_idx];
  end

  // command decode from the 24-bit word when its last byte lands
  always_comb begin
    exec    = (r_reg.st == QDC_ST_RX) && scl_r && (r_reg.bitc[2:0] == QDC_BITS)
              && (r_reg.bidx == 2'd3) && !stop && !start;
    cmd     = r_reg.sh24[15:12];
    wr_data = {r_reg.sh24[7:0], rx_byte};
    ch_wr   = '0;
    ch_upd  = '0;
    if (exec && r_reg.por) begin
      if (cmd == QDC_CMD_WR || cmd == QDC_CMD_WRUPD) begin
        ch_wr = r_reg.sh24[11:8];
      end
      if (cmd == QDC_CMD_UPD || cmd == QDC_CMD_WRUPD) begin
        ch_upd = r_reg.sh24[11:8];
      end
      // strobe held low: writes pass straight through
      if (!pin[QDC_P_LD]) begin
        ch_upd = ch_upd | ch_wr;
      end
    end
    // one pulse updates all channels with pending data together
    if (ld_fall || r_reg.swld) begin
      ch_upd = '1;
    end
    if (!ld_ok) begin
      ch_upd = '0;
    end
  end

  // apb decode and read mux
  always_comb begin
    hit  = 1'b0;
    rd_v = 32'h0000_0000;
    if (paddr == QDC_CTRL) begin
      hit  = 1'b1;
      rd_v = {31'h0000_0000, r_reg.ref_en};
    end else if (paddr == QDC_STAT) begin
      hit  = 1'b1;
      rd_v = {22'h00_0000, pin[QDC_P_RST], pin[QDC_P_A1], pin[QDC_P_A0],
              pin[QDC_P_RSEL], pin[QDC_P_SPAN], ch_pend, r_reg.por};
    end else if (paddr[1:0] == 2'b00 && paddr[7:4] == QDC_IN_PAGE) begin
      hit  = 1'b1;
      rd_v = {16'h0000, ch_in[paddr[3:2]]};
    end else if (paddr[1:0] == 2'b00 && paddr[7:4] == QDC_DAC_PAGE) begin
      hit  = 1'b1;
      rd_v = {16'h0000, ch_dac[paddr[3:2]]};
    end
  end

  // next state
  always_comb begin
    r_next      = r_reg;
    r_next.sclp = pin[QDC_P_SCL];
    r_next.sdap = pin[QDC_P_SDA];
    r_next.ldp  = pin[QDC_P_LD];
    r_next.rstp = pin[QDC_P_RST];
    r_next.swld = 1'b0;
    if (pin[QDC_P_RST]) begin
      r_next.por = 1'b1;
    end
    // apb: data latched in setup, write taken in access
    if (psel && !penable) begin
      r_next.rdata = rd_v;
    end
    if (psel && penable && pwrite && paddr == QDC_CTRL) begin
      r_next.ref_en = pwdata[QDC_CTRL_REF];
      r_next.swld   = pwdata[QDC_CTRL_LD];
    end
    // two-wire slave
    if (stop) begin
      r_next.st = QDC_ST_IDLE;
      r_next.oe = 1'b0;
    end else if (start) begin
      r_next.st   = QDC_ST_RX;
      r_next.bitc = 4'd0;
      r_next.bidx = 2'd0;
      r_next.oe   = 1'b0;
    end else begin
      unique case (r_reg.st)
        QDC_ST_IDLE: begin
          r_next.oe = 1'b0;
        end
        QDC_ST_RX: begin
          if (scl_r) begin
            r_next.sh   = rx_byte;
            r_next.bitc = r_reg.bitc + 4'd1;
            if (r_reg.bitc[2:0] == QDC_BITS) begin
              r_next.bitc = 4'd0;
              r_next.ackd = 1'b0;
              if (r_reg.bidx == 2'd0) begin
                if (rx_byte[7:1] == my_addr) begin
                  r_next.rw   = rx_byte[0];
                  r_next.st   = QDC_ST_ACK;
                  r_next.bidx = 2'd1;
                end else begin
                  r_next.st = QDC_ST_IDLE;
                end
              end else begin
                r_next.sh24 = {r_reg.sh24[15:0], rx_byte};
                r_next.st   = QDC_ST_ACK;
                if (r_reg.bidx == 2'd1) begin
                  r_next.sel = rx_byte[3:0];
                end
                r_next.bidx = (r_reg.bidx == 2'd3) ? 2'd1 : r_reg.bidx + 2'd1;
              end
            end
          end
        end
        QDC_ST_ACK: begin
          if (scl_f) begin
            if (!r_reg.ackd) begin
              r_next.ackd = 1'b1;
              r_next.oe   = 1'b1;
            end else begin
              r_next.ackd = 1'b0;
              if (r_reg.rw) begin
                r_next.st    = QDC_ST_TX;
                r_next.txsel = 1'b0;
                r_next.tx    = rd_word[15:8];
                r_next.oe    = ~rd_word[15];
                r_next.bitc  = 4'd0;
              end else begin
                r_next.st = QDC_ST_RX;
                r_next.oe = 1'b0;
              end
            end
          end
        end
        QDC_ST_TX: begin
          if (scl_r) begin
            r_next.bitc = r_reg.bitc + 4'd1;
          end else if (scl_f) begin
            if (r_reg.bitc == QDC_TXBITS) begin
              r_next.oe = 1'b0;
              r_next.st = QDC_ST_MACK;
            end else begin
              r_next.tx = {r_reg.tx[6:0], 1'b0};
              r_next.oe = ~r_reg.tx[6];
            end
          end
        end
        QDC_ST_MACK: begin
          if (scl_r && pin[QDC_P_SDA]) begin
            r_next.st = QDC_ST_IDLE;
          end else if (scl_f) begin
            r_next.txsel = ~r_reg.txsel;
            r_next.tx    = r_reg.txsel ? rd_word[15:8] : rd_word[7:0];
            r_next.oe    = r_reg.txsel ? ~rd_word[15] : ~rd_word[7];
            r_next.bitc  = 4'd0;
            r_next.st    = QDC_ST_TX;
          end
        end
        default: begin
          r_next.st = QDC_ST_IDLE;
          r_next.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg        <= '0;
      r_reg.st     <= QDC_ST_IDLE;
      r_reg.sclp   <= 1'b1;
      r_reg.sdap   <= 1'b1;
      r_reg.ldp    <= 1'b1;
      r_reg.ref_en <= QDC_REF_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs
  assign pready      = 1'b1;
  assign prdata      = r_reg.rdata;
  assign pslverr     = psel & penable & ~hit;
  assign sda_out     = 1'b0;
  assign sda_oe      = r_reg.oe;
  assign dac_code    = ch_dac;
  assign span_double = pin[QDC_P_SPAN];
  assign ref_out_en  = r_reg.ref_en;
endmodule : qdc_top
`default_nettype wire

// ---- verilog/qdc_pkg.sv ----
// qdc_pkg: constants and types shared by the quad converter control block.
// assumes a single 20 MHz pclk domain; all pins are synchronised before use.
// Notes on behaviour
// - serial data and serial clock shift words into or out of a 24-bit input shift register.
// - the serial data line is open drain: the device only pulls it low or lets it go.
// - the load strobe works in an asynchronous (pulsed) and a synchronous (held low) mode.
// - a low pulse on the load strobe copies every input register holding new data to its output.
// - one strobe pulse updates all affected channels in the same clock cycle.
// - the block works correctly with the load strobe tied permanently low.
// - the span select level picks a span of one reference (low) or two references (high).
// - the first address strap sets bit 0 of the 7-bit bus target address.
// - the second address strap sets bit 1 of the 7-bit bus target address.
// - the converter reset input acts on its falling edge, apart from bus activity.
// - while the converter reset input is low, no strobe moves data to the outputs.
// - a reset loads input and output registers with zero or midscale per the level select.
// - a reset input held low at power-up delays power-on initialisation until release.
// - at power-up all channels start at zero scale (select low) or midscale (select high).
// - the internal reference is enabled after power-up until software turns it off.
package qdc_pkg;
  localparam int          QDC_NCH       = 4;
  localparam int          QDC_DW        = 16;
  localparam int          QDC_SHW       = 24;
  localparam logic [15:0] QDC_ZERO      = 16'h0000;
  localparam logic [15:0] QDC_MID       = 16'h8000;
  // upper address bits: arbitrary value
  localparam logic [4:0]  QDC_ADDR_HI   = 5'h0c;
  // apb map
  localparam logic [7:0]  QDC_CTRL      = 8'h00;
  localparam logic [7:0]  QDC_STAT      = 8'h04;
  localparam logic [3:0]  QDC_IN_PAGE   = 4'h1;
  localparam logic [3:0]  QDC_DAC_PAGE  = 4'h2;
  localparam int          QDC_CTRL_REF  = 0;
  localparam int          QDC_CTRL_LD   = 1;
  localparam logic        QDC_REF_RST   = 1'b1;
  // synchronised pin vector positions
  localparam int          QDC_P_SCL     = 0;
  localparam int          QDC_P_SDA     = 1;
  localparam int          QDC_P_LD      = 2;
  localparam int          QDC_P_SPAN    = 3;
  localparam int          QDC_P_A0      = 4;
  localparam int          QDC_P_A1      = 5;
  localparam int          QDC_P_RSEL    = 6;
  localparam int          QDC_P_RST     = 7;
  localparam int          QDC_NPIN      = 8;
  localparam logic [7:0]  QDC_PIN_RST   = 8'h07;
  localparam logic [2:0]  QDC_BITS      = 3'h7;
  localparam logic [3:0]  QDC_TXBITS    = 4'h8;

  typedef enum logic [3:0] {
    QDC_CMD_WR    = 4'h1,
    QDC_CMD_UPD   = 4'h2,
    QDC_CMD_WRUPD = 4'h3
  } qdc_cmd_t;

  typedef enum logic [2:0] {
    QDC_ST_IDLE = 3'b000,
    QDC_ST_RX   = 3'b001,
    QDC_ST_ACK  = 3'b010,
    QDC_ST_TX   = 3'b011,
    QDC_ST_MACK = 3'b100
  } qdc_st_t;
endpackage : qdc_pkg

// ---- verilog/qdc_sync.sv ----
// qdc_sync: two-flop synchroniser for a vector of pin levels.
// assumes each bit is an independent slow level or a sampled link clock.
`timescale 1ns/1ps
`default_nettype none
module qdc_sync #(
  parameter int              W   = 8,
  parameter logic [W-1:0]    RST = '0
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // levels
  input  wire logic [W-1:0]  d,
  output logic [W-1:0]       q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } qdc_sync_t;

  qdc_sync_t s_reg;
  qdc_sync_t s_next;

  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '{s1: RST, s2: RST};
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;
endmodule : qdc_sync
`default_nettype wire

// ---- verilog/qdc_chan.sv ----
// qdc_chan: one channel's input register and output register.
// assumes init, wr and upd are single-cycle pulses from the control logic.
`timescale 1ns/1ps
`default_nettype none
module qdc_chan
  import qdc_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // control
  input  wire logic              init,
  input  wire logic [QDC_DW-1:0] init_val,
  input  wire logic              wr,
  input  wire logic [QDC_DW-1:0] wdata,
  input  wire logic              upd,
  // state
  output logic [QDC_DW-1:0]      in_code,
  output logic [QDC_DW-1:0]      dac_code,
  output logic                   pending
);
  typedef struct packed {
    logic [QDC_DW-1:0] in_r;
    logic [QDC_DW-1:0] dac_r;
    logic              pend;
  } qdc_chan_t;

  qdc_chan_t c_reg;
  qdc_chan_t c_next;

  always_comb begin
    c_next = c_reg;
    if (init) begin
      c_next.in_r  = init_val;
      c_next.dac_r = init_val;
      c_next.pend  = 1'b0;
    end else begin
      if (wr) begin
        c_next.in_r = wdata;
        c_next.pend = 1'b1;
      end
      // copy only when new data is there; a write in the same cycle goes along
      if (upd && (c_reg.pend || wr)) begin
        c_next.dac_r = c_next.in_r;
        c_next.pend  = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_reg <= '{in_r: QDC_ZERO, dac_r: QDC_ZERO, pend: 1'b0};
    end else begin
      c_reg <= c_next;
    end
  end

  assign in_code  = c_reg.in_r;
  assign dac_code = c_reg.dac_r;
  assign pending  = c_reg.pend;
endmodule : qdc_chan
`default_nettype wire

// ---- dv/qdc_top_sva.sv ----
// qdc_top_sva: port-level checks of the converter control block.
// assumes a bind onto qdc_top, one pclk domain.
`timescale 1ns/1ps
`default_nettype none
module qdc_top_sva
  import qdc_pkg::*;
(
  // clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // apb
  input wire logic [7:0]           paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          pwdata,
  // pins
  input wire logic                 scl,
  input wire logic                 sda_out,
  input wire logic                 sda_oe,
  input wire logic                 span_select,
  input wire logic                 reset_level_select,
  input wire logic                 dac_reset_n,
  // converter side
  input wire logic [qdc_pkg::QDC_NCH-1:0][qdc_pkg::QDC_DW-1:0] dac_code,
  input wire logic                 span_double,
  input wire logic                 ref_out_en
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pwrite && paddr == QDC_CTRL;
  property p_od;
    sda_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_sda_chg;
    $changed(sda_oe) |-> !scl;
  endproperty
  a_sda_chg: assert property (p_sda_chg) else $error("sda moved while scl high");
  property p_span_hi;
    span_select [*5] |-> span_double;
  endproperty
  a_span_hi: assert property (p_span_hi) else $error("span not doubled");
  property p_span_lo;
    !span_select [*5] |-> !span_double;
  endproperty
  a_span_lo: assert property (p_span_lo) else $error("span not single");
  property p_rst_hold;
    (!dac_reset_n) [*8] |=> $stable(dac_code);
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("output moved in reset");
  property p_rst_val;
    $fell(dac_reset_n) ##0 (!dac_reset_n && $stable(reset_level_select)) [*8]
      |-> dac_code == {QDC_NCH{reset_level_select ? QDC_MID : QDC_ZERO}};
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("wrong reset code");
  property p_ref_on;
    ctrl_wr && pwdata[QDC_CTRL_REF] |=> ref_out_en;
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference not on");
  property p_ref_off;
    ctrl_wr && !pwdata[QDC_CTRL_REF] |=> !ref_out_en;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference not off");
  property p_ref_keep;
    !ctrl_wr |=> $stable(ref_out_en);
  endproperty
  a_ref_keep: assert property (p_ref_keep) else $error("reference moved");
endmodule : qdc_top_sva
`default_nettype wire

// ---- dv/qdc_bus_model.sv ----
// qdc_bus_model: two-wire bus master and load strobe driver.
// assumes sda resolved outside with a pull-up; scl paced by pclk.
`timescale 1ns/1ps
`default_nettype none
module qdc_bus_model (
  // clock
  input  wire logic pclk,
  // two-wire bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low,
  // strobe
  output logic      load_strobe_n
);
  // three bytes seen on sda after the address of the last frame
  logic [23:0] got;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    load_strobe_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // scl low 5, high 3: 400 ns; data set mid-low
  task automatic put_bit(input logic b, output logic seen);
    scl <= 1'b0;
    tick(2);
    sda_low <= !b;
    tick(3);
    scl <= 1'b1;
    tick(2);
    seen = sda;
    tick(1);
  endtask : put_bit
  // start, address, one 24-bit word msb first, stop; a read releases sda
  // after the address, acks two bytes and nacks the third
  task automatic frame(input logic [7:0] adr, input logic [7:0] cmd,
                       input logic [15:0] d, output logic [3:0] acks);
    logic [31:0] w;
    logic        s;
    logic        rd;
    w  = {adr, cmd, d};
    rd = adr[0];
    sda_low <= 1'b1;
    tick(3);
    for (int i = 31; i >= 0; i--) begin
      put_bit(w[i] | (rd & (i < 24)), s);
      w[i] = s;
      if (i % 8 == 0) begin
        put_bit(!(rd && i > 0 && i < 24), s);
        acks[i / 8] = !s;
      end
    end
    got = w[23:0];
    scl <= 1'b0;
    tick(2);
    sda_low <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_low <= 1'b0;
    tick(4);
  endtask : frame
  task automatic strobe(input logic v);
    load_strobe_n <= v;
    tick(1);
  endtask : strobe
  task automatic strobe_pulse;
    strobe(1'b0);
    tick(1);
    strobe(1'b1);
  endtask : strobe_pulse
endmodule : qdc_bus_model
`default_nettype wire

// ---- dv/qdc_top_bench.sv ----
// qdc_top_bench: self-checking bench of the converter control block.
// assumes qdc_bus_model as two-wire master; straps give address bits 2'b10.
`timescale 1ns/1ps
`default_nettype none
module qdc_top_bench;
  import qdc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        scl, sda_out, sda_oe, sda_low, strobe_n, err;
  logic        span_select, strap0, strap1, rsel, dac_reset_n, span_double, ref_out_en;
  logic [QDC_NCH-1:0][QDC_DW-1:0] dac_code, snap;
  logic [3:0]  acks;
  wire logic   sda;
  int          errors, n_tests, n;
  assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
  always #25 pclk = ~pclk;
  qdc_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .load_strobe_n(strobe_n), .span_select(span_select),
    .addr_strap_bit0(strap0), .addr_strap_bit1(strap1), .reset_level_select(rsel),
    .dac_reset_n(dac_reset_n), .dac_code(dac_code), .span_double(span_double),
    .ref_out_en(ref_out_en));
  qdc_bus_model bus_u (.pclk(pclk), .sda(sda), .scl(scl), .sda_low(sda_low),
    .load_strobe_n(strobe_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int w;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    tick(1);
    penable <= 1'b1;
    w = 0;
    do begin
      tick(1);
      w++;
    end while (pready !== 1'b1 && w < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
    if (w >= 20) begin
      errors++;
      final_report();
    end
  endtask : apb
  task automatic chk_all(input logic [15:0] v, input string msg);
    for (int i = 0; i < QDC_NCH; i++) begin
      check({16'h0, dac_code[i]}, {16'h0, v}, msg);
    end
  endtask : chk_all
  task automatic s_power;
    chk_all(QDC_ZERO, "power-up zero");
    check({31'h0, ref_out_en}, 32'h1, "ref on");
    for (int k = 1; k >= 0; k--) begin
      span_select <= k[0];
      tick(6);
      check({31'h0, span_double}, k, "span");
    end
  endtask : s_power
  task automatic s_apb;
    apb(1'b0, QDC_STAT, 32'h0);
    check({30'h0, rd[8:7]}, 32'h2, "straps");
    apb(1'b1, QDC_CTRL, 32'h0);
    check({31'h0, ref_out_en}, 32'h0, "ref off");
    apb(1'b1, QDC_CTRL, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped");
  endtask : s_apb
  task automatic s_strobe;
    bus_u.frame({QDC_ADDR_HI, 2'b10, 1'b0}, 8'h15, 16'h1234, acks);
    check({28'h0, acks}, 32'hf, "own address");
    for (int k = 0; k < 2; k++) begin
      bus_u.frame({QDC_ADDR_HI, k[0], k[0], 1'b0}, 8'h12, 16'hffff, acks);
      check({31'h0, acks[3]}, 32'h0, "other address");
    end
    check({16'h0, dac_code[0]}, 32'h0, "held before strobe");
    n = 0;
    fork
      bus_u.strobe_pulse();
      begin
        while (dac_code[0] === QDC_ZERO && n < 12) begin
          @(negedge pclk);
          n++;
        end
        snap = dac_code;
      end
    join
    if (n >= 12) begin
      errors++;
      final_report();
    end
    check({16'h0, snap[0]}, 32'h1234, "ch0 loaded");
    check({16'h0, snap[2]}, 32'h1234, "ch2 same cycle");
    check({16'h0, snap[1]}, 32'h0, "ch1 untouched");
    bus_u.frame({QDC_ADDR_HI, 2'b10, 1'b0}, 8'h32, 16'h0f5a, acks);
    check({16'h0, dac_code[1]}, 32'h0f5a, "write and update");
    bus_u.frame({QDC_ADDR_HI, 2'b10, 1'b1}, 8'h00, 16'h0000, acks);
    check({8'h0, bus_u.got}, 32'h0f5a0f, "read back");
    bus_u.frame({QDC_ADDR_HI, 2'b10, 1'b0}, 8'h18, 16'h7e81, acks);
    apb(1'b0, QDC_STAT, 32'h0);
    check({28'h0, rd[4:1]}, 32'h8, "pending");
    bus_u.frame({QDC_ADDR_HI, 2'b10, 1'b0}, 8'h28, 16'h0000, acks);
    check({16'h0, dac_code[3]}, 32'h7e81, "update command");
    bus_u.frame({QDC_ADDR_HI, 2'b10, 1'b0}, 8'h14, 16'hc3c3, acks);
    apb(1'b1, QDC_CTRL, 32'h3);
    tick(2);
    check({16'h0, dac_code[2]}, 32'hc3c3, "software load");
  endtask : s_strobe
  task automatic s_held;
    bus_u.strobe(1'b0);
    tick(6);
    bus_u.frame({QDC_ADDR_HI, 2'b10, 1'b0}, 8'h18, 16'hbeef, acks);
    check({16'h0, dac_code[3]}, 32'hbeef, "through with strobe low");
    bus_u.strobe(1'b1);
    tick(4);
  endtask : s_held
  task automatic s_reset;
    rsel <= 1'b1;
    tick(2);
    dac_reset_n <= 1'b0;
    tick(8);
    chk_all(QDC_MID, "reset midscale");
    apb(1'b0, 8'h14, 32'h0);
    check(rd, {16'h0, QDC_MID}, "input reg reset");
    bus_u.frame({QDC_ADDR_HI, 2'b10, 1'b0}, 8'h11, 16'h5555, acks);
    bus_u.strobe_pulse();
    tick(6);
    check({16'h0, dac_code[0]}, {16'h0, QDC_MID}, "strobe in reset");
    dac_reset_n <= 1'b1;
    tick(6);
  endtask : s_reset
  task automatic s_por;
    presetn <= 1'b0;
    dac_reset_n <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    tick(10);
    apb(1'b0, QDC_STAT, 32'h0);
    check({31'h0, rd[0]}, 32'h0, "init held off");
    dac_reset_n <= 1'b1;
    tick(8);
    chk_all(QDC_MID, "late init midscale");
  endtask : s_por
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {span_select, strap0, rsel} = '0;
    strap1 = 1'b1;
    dac_reset_n = 1'b1;
    errors = 0;
    n_tests = 0;
    tick(10);
    presetn <= 1'b1;
    tick(10);
    s_power();
    s_apb();
    s_strobe();
    s_held();
    s_reset();
    s_por();
    final_report();
  end
endmodule : qdc_top_bench
bind qdc_top qdc_top_sva chk_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .scl(scl),
  .sda_out(sda_out), .sda_oe(sda_oe), .span_select(span_select),
  .reset_level_select(reset_level_select), .dac_reset_n(dac_reset_n),
  .dac_code(dac_code), .span_double(span_double), .ref_out_en(ref_out_en));
`default_nettype wire
